// File: rtl/ffc_top.sv
// control and protection sequencing of a current-mode flyback controller
`timescale 1ns/1ps
`include "ffc_regs.svh"
module ffc_top #(
  parameter int unsigned SS_CYC        = 400000,
  parameter int unsigned FAULT_CYC     = 2000000,
  parameter int unsigned RETRY_CYC     = 4000000,
  parameter int unsigned TRAN_CYC      = 240000000,
  parameter int unsigned OFF_SHORT_CYC = 6000000,
  parameter int unsigned OFF_LONG_CYC  = 20000000
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cs_fb_trip,
  input  wire logic       cs_limit_trip,
  input  wire logic       cs_soft_trip,
  input  wire logic       cs_stop_trip,
  input  wire logic       cs_tran_trip,
  input  wire logic       fb_opc_above,
  input  wire logic       fb_off_below,
  input  wire logic       fb_on_above,
  input  wire logic       supply_start_above,
  input  wire logic       supply_low_below,
  input  wire logic       supply_high_above,
  input  wire logic       line_ok,
  input  wire logic       line_cmp,
  input  wire logic [2:0] line_adc,
  input  wire logic       line_sample_evt,
  input  wire logic       line_clear_evt,
  input  wire logic       thermal_shutdown,
  input  wire logic       ext_latch_req,
  input  wire logic       opt_freq_fast,
  input  wire logic       opt_auto_retry,
  input  wire logic       opt_off_long,
  output logic            gate_drive,
  output logic [3:0]      softstart_step,
  output logic [15:0]     slope_ramp,
  output logic            opc_enable,
  output logic [2:0]      line_peak,
  output logic            line_peak_valid,
  output logic            line_peak_clear,
  output logic            internal_supply_on,
  output logic            startup_source_on,
  output logic            protect_latched
);
  localparam int unsigned NSYNC = 23;

  // refuse counts the logic cannot serve
  if (SS_CYC < `FFC_SS_STEPS || FAULT_CYC < 1 || RETRY_CYC < 1 || TRAN_CYC < 1 ||
      OFF_SHORT_CYC < 1 || OFF_LONG_CYC < 1)
  begin : g_bad_param
    $error("ffc_top: timing parameters too small");
  end

  localparam logic [31:0] SS_STEP_CYC = 32'(SS_CYC / `FFC_SS_STEPS);
  localparam logic [9:0]  LEB_CYC     = 10'(`FFC_LEB_CYC);

  // two-stage synchroniser on every pin input except clk and nrst
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign async_in = {cs_fb_trip, cs_limit_trip, cs_soft_trip, cs_stop_trip, cs_tran_trip,
                     fb_opc_above, fb_off_below, fb_on_above, supply_start_above,
                     supply_low_below, supply_high_above, line_ok, line_cmp, line_adc,
                     line_sample_evt, line_clear_evt, thermal_shutdown, ext_latch_req,
                     opt_freq_fast, opt_auto_retry, opt_off_long};

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // synchronised views
  logic       s_fb;
  logic       s_lim;
  logic       s_soft;
  logic       s_stop;
  logic       s_tran;
  logic       s_opc;
  logic       s_fb_off;
  logic       s_fb_on;
  logic       s_vstart;
  logic       s_vlow;
  logic       s_vhigh;
  logic       s_line_ok;
  logic       s_lcmp;
  logic [2:0] s_adc;
  logic       s_sample;
  logic       s_clear;
  logic       s_hot;
  logic       s_ext;
  logic [2:0] s_opt;
  assign {s_fb, s_lim, s_soft, s_stop, s_tran, s_opc, s_fb_off, s_fb_on, s_vstart,
          s_vlow, s_vhigh, s_line_ok, s_lcmp, s_adc, s_sample, s_clear, s_hot, s_ext,
          s_opt} = sync2_reg;

  // options are followed only while the stage is idle
  ffc_pkg::ffc_state_t state_reg;
  ffc_pkg::ffc_state_t state_next;
  logic [2:0]          opt_reg;
  logic                fast;
  logic                auto_rt;
  logic                long_off;
  assign fast     = opt_reg[2];
  assign auto_rt  = opt_reg[1];
  assign long_off = opt_reg[0];

  // oscillator, sawtooth and on-time counters
  logic [9:0]  per_cnt_reg;
  logic [9:0]  on_cnt_reg;
  logic [9:0]  per_last;
  logic [9:0]  maxon_last;
  logic [15:0] ramp_reg;
  logic        per_end;
  logic        sw_en;
  logic        in_soft;
  logic        blanked;
  logic        cmp_off;
  logic        maxon_hit;
  logic        turn_on;
  logic        turn_off;
  logic        next_sw;
  assign per_last   = fast ? 10'(`FFC_PER_FAST_CYC - 1) : 10'(`FFC_PER_SLOW_CYC - 1);
  assign maxon_last = fast ? 10'(`FFC_MAXON_FAST_CYC - 1) : 10'(`FFC_MAXON_SLOW_CYC - 1);
  assign per_end    = (per_cnt_reg == per_last);
  assign in_soft    = (state_reg == ffc_pkg::ffc_st_soft);
  assign sw_en      = in_soft || (state_reg == ffc_pkg::ffc_st_run);
  assign blanked    = (on_cnt_reg < LEB_CYC);
  assign cmp_off    = !blanked && (s_fb || s_lim || (in_soft && s_soft));
  assign maxon_hit  = (on_cnt_reg == maxon_last);
  assign next_sw    = (state_next == ffc_pkg::ffc_st_soft) || (state_next == ffc_pkg::ffc_st_run);
  assign turn_on    = sw_en && next_sw && (per_cnt_reg == 10'h000);
  assign turn_off   = gate_drive && (!next_sw || cmp_off || maxon_hit);

  // per-cycle fault records
  logic       lim_seen_reg;
  logic       maxon_seen_reg;
  logic       stop_seen_reg;
  logic       tran_seen_reg;
  logic       ovl_reg;
  logic       tran_reg;
  logic [2:0] short_cnt_reg;
  logic       short_hit;
  assign short_hit = (short_cnt_reg == 3'(`FFC_SHORT_COUNT));

  // gate drive, ramp and cycle records
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      per_cnt_reg    <= 10'h000;
      on_cnt_reg     <= 10'h000;
      gate_drive     <= 1'b0;
      ramp_reg       <= 16'h0000;
      lim_seen_reg   <= 1'b0;
      maxon_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
      tran_seen_reg  <= 1'b0;
      ovl_reg        <= 1'b0;
      tran_reg       <= 1'b0;
      short_cnt_reg  <= 3'h0;
    end
    else
    begin
      per_cnt_reg <= per_end ? 10'h000 : per_cnt_reg + 10'h001;
      ramp_reg    <= per_end ? 16'h0000 : ramp_reg + {8'h00, fast ? `FFC_SLOPE_FAST : `FFC_SLOPE_SLOW};
      if (turn_on)
        gate_drive <= 1'b1;
      else if (turn_off)
        gate_drive <= 1'b0;
      on_cnt_reg <= gate_drive ? on_cnt_reg + 10'h001 : 10'h000;
      if (per_end)
      begin
        ovl_reg        <= lim_seen_reg || maxon_seen_reg;
        tran_reg       <= tran_seen_reg;
        short_cnt_reg  <= !sw_en || !stop_seen_reg ? 3'h0 :
                          short_hit ? short_cnt_reg : short_cnt_reg + 3'h1;
        lim_seen_reg   <= 1'b0;
        maxon_seen_reg <= 1'b0;
        stop_seen_reg  <= 1'b0;
        tran_seen_reg  <= 1'b0;
      end
      else if (gate_drive && !blanked)
      begin
        lim_seen_reg   <= lim_seen_reg || s_lim;
        maxon_seen_reg <= maxon_seen_reg || (maxon_hit && !cmp_off);
        stop_seen_reg  <= stop_seen_reg || s_stop;
        tran_seen_reg  <= tran_seen_reg || s_tran;
      end
      if (!sw_en)
      begin
        ovl_reg  <= 1'b0;
        tran_reg <= 1'b0;
      end
    end
  end

  // qualification timers
  ffc_tmr_if t_low ();
  ffc_tmr_if t_high ();
  ffc_tmr_if t_ext ();
  ffc_tmr_if t_hot ();
  ffc_tmr_if t_offm ();
  ffc_tmr_if t_ovl ();
  ffc_tmr_if t_tran ();
  assign t_low.run    = sw_en && s_vlow;
  assign t_low.limit  = 32'(`FFC_US_CYC(`FFC_QUAL_SUPPLY_US));
  assign t_high.run   = sw_en && s_vhigh;
  assign t_high.limit = 32'(`FFC_US_CYC(`FFC_QUAL_SUPPLY_US));
  assign t_ext.run    = sw_en && s_ext;
  assign t_ext.limit  = fast ? 32'(`FFC_US_CYC(`FFC_QUAL_EXT_FAST_US)) :
                               32'(`FFC_US_CYC(`FFC_QUAL_EXT_SLOW_US));
  assign t_hot.run    = s_hot;
  assign t_hot.limit  = 32'(`FFC_US_CYC(`FFC_QUAL_SUPPLY_US));
  assign t_offm.run   = sw_en && s_fb_off;
  assign t_offm.limit = long_off ? 32'(OFF_LONG_CYC) : 32'(OFF_SHORT_CYC);
  assign t_ovl.run    = ovl_reg;
  assign t_ovl.limit  = 32'(FAULT_CYC);
  assign t_tran.run   = tran_reg;
  assign t_tran.limit = 32'(TRAN_CYC);

  ffc_qual u_low  (.clk(clk), .nrst(nrst), .t(t_low));
  ffc_qual u_high (.clk(clk), .nrst(nrst), .t(t_high));
  ffc_qual u_ext  (.clk(clk), .nrst(nrst), .t(t_ext));
  ffc_qual u_hot  (.clk(clk), .nrst(nrst), .t(t_hot));
  ffc_qual u_offm (.clk(clk), .nrst(nrst), .t(t_offm));
  ffc_qual u_ovl  (.clk(clk), .nrst(nrst), .t(t_ovl));
  ffc_qual u_tran (.clk(clk), .nrst(nrst), .t(t_tran));

  // soft-start and retry counters
  logic [31:0] ss_cnt_reg;
  logic [3:0]  ss_step_reg;
  logic [31:0] retry_cnt_reg;
  logic        ss_tick;
  logic        retry_done;
  logic        prot_evt;
  logic        hard_evt;
  logic        start_ok;
  assign ss_tick    = in_soft && (ss_cnt_reg == SS_STEP_CYC - 32'h1);
  assign retry_done = (retry_cnt_reg == 32'(RETRY_CYC) - 32'h1);
  assign prot_evt   = t_ovl.done || t_tran.done || short_hit || t_low.done;
  assign hard_evt   = t_ext.done || t_high.done;
  assign start_ok   = s_vstart && s_line_ok && !s_hot;

  // sequencing, brown-out has top priority
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ffc_pkg::ffc_st_off:
        if (start_ok)
          state_next = ffc_pkg::ffc_st_soft;
      ffc_pkg::ffc_st_sleep:
        if (start_ok && s_fb_on)
          state_next = ffc_pkg::ffc_st_soft;
      ffc_pkg::ffc_st_soft,
      ffc_pkg::ffc_st_run:
        if (t_hot.done)
          state_next = ffc_pkg::ffc_st_off;
        else if (hard_evt)
          state_next = ffc_pkg::ffc_st_latch;
        else if (prot_evt)
          state_next = auto_rt ? ffc_pkg::ffc_st_retry : ffc_pkg::ffc_st_latch;
        else if (t_offm.done)
          state_next = ffc_pkg::ffc_st_sleep;
        else if (ss_tick && ss_step_reg == 4'(`FFC_SS_STEPS - 1))
          state_next = ffc_pkg::ffc_st_run;
      ffc_pkg::ffc_st_retry:
        if (retry_done)
          state_next = ffc_pkg::ffc_st_off;
      ffc_pkg::ffc_st_latch:
        state_next = ffc_pkg::ffc_st_latch;
    endcase
    if (!s_line_ok)
      state_next = ffc_pkg::ffc_st_off;
  end

  // state, options, soft-start and retry registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg     <= ffc_pkg::ffc_st_off;
      opt_reg       <= 3'h0;
      ss_cnt_reg    <= 32'h0;
      ss_step_reg   <= 4'h0;
      retry_cnt_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ffc_pkg::ffc_st_off)
        opt_reg <= s_opt;
      ss_cnt_reg <= (!in_soft || ss_tick) ? 32'h0 : ss_cnt_reg + 32'h1;
      if (!sw_en)
        ss_step_reg <= 4'h0;
      else if (ss_tick)
        ss_step_reg <= ss_step_reg + 4'h1;
      retry_cnt_reg <= (state_reg == ffc_pkg::ffc_st_retry) ? retry_cnt_reg + 32'h1 : 32'h0;
    end
  end

  // line peak sampling and validation
  logic       lcmp_prev_reg;
  logic       samp_prev_reg;
  logic       clr_prev_reg;
  logic [1:0] quiet_reg;
  logic       samp_pulse;
  logic       clr_pulse;
  logic       lcmp_rise;
  logic       lcmp_fall;
  assign samp_pulse = s_sample && !samp_prev_reg;
  assign clr_pulse  = s_clear && !clr_prev_reg;
  assign lcmp_rise  = s_lcmp && !lcmp_prev_reg;
  assign lcmp_fall  = !s_lcmp && lcmp_prev_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lcmp_prev_reg   <= 1'b0;
      samp_prev_reg   <= 1'b0;
      clr_prev_reg    <= 1'b0;
      quiet_reg       <= 2'h0;
      line_peak       <= 3'h0;
      line_peak_valid <= 1'b0;
      line_peak_clear <= 1'b0;
    end
    else
    begin
      lcmp_prev_reg   <= s_lcmp;
      samp_prev_reg   <= s_sample;
      clr_prev_reg    <= s_clear;
      line_peak_clear <= clr_pulse;
      if (lcmp_rise || lcmp_fall || s_lcmp)
        quiet_reg <= 2'h0;
      else if (samp_pulse && quiet_reg != 2'(`FFC_QUIET_SAMPLES))
        quiet_reg <= quiet_reg + 2'h1;
      if (samp_pulse)
      begin
        line_peak       <= s_adc;
        line_peak_valid <= !lcmp_rise && !lcmp_fall && !s_lcmp &&
                           quiet_reg >= 2'(`FFC_QUIET_SAMPLES - 1);
      end
      else if (lcmp_rise || lcmp_fall)
        line_peak_valid <= 1'b0;
    end
  end

  // registered status and enables
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      softstart_step     <= 4'h0;
      slope_ramp         <= 16'h0000;
      opc_enable         <= 1'b0;
      internal_supply_on <= 1'b1;
      startup_source_on  <= 1'b1;
      protect_latched    <= 1'b0;
    end
    else
    begin
      softstart_step     <= (state_reg == ffc_pkg::ffc_st_run) ? 4'hf : ss_step_reg;
      slope_ramp         <= ramp_reg;
      opc_enable         <= sw_en && s_opc;
      internal_supply_on <= (state_next != ffc_pkg::ffc_st_sleep);
      startup_source_on  <= !t_hot.done;
      protect_latched    <= (state_next == ffc_pkg::ffc_st_latch);
    end
  end
endmodule

// File: rtl/ffc_regs.svh
// constants for the flyback fault and soft-start logic
`ifndef FFC_REGS_SVH
`define FFC_REGS_SVH
`define FFC_CLK_MHZ      40
`define FFC_LEB_NS       250
`define FFC_LEB_CYC      ((`FFC_LEB_NS * `FFC_CLK_MHZ + 999) / 1000)
`define FFC_F_SLOW_KHZ   65
`define FFC_F_FAST_KHZ   100
`define FFC_PER_SLOW_CYC ((`FFC_CLK_MHZ * 1000) / `FFC_F_SLOW_KHZ)
`define FFC_PER_FAST_CYC ((`FFC_CLK_MHZ * 1000) / `FFC_F_FAST_KHZ)
`define FFC_MAXON_SLOW_NS 12300
`define FFC_MAXON_FAST_NS 8000
`define FFC_MAXON_SLOW_CYC ((`FFC_MAXON_SLOW_NS * `FFC_CLK_MHZ) / 1000)
`define FFC_MAXON_FAST_CYC ((`FFC_MAXON_FAST_NS * `FFC_CLK_MHZ) / 1000)
`define FFC_QUAL_SUPPLY_US 10
`define FFC_QUAL_EXT_SLOW_US 55
`define FFC_QUAL_EXT_FAST_US 35
`define FFC_US_CYC(us)   ((us) * `FFC_CLK_MHZ)
`define FFC_SS_STEPS     15
`define FFC_SHORT_COUNT  4
`define FFC_QUIET_SAMPLES 2
`define FFC_SLOPE_SLOW   8'h0d
`define FFC_SLOPE_FAST   8'h14
`endif

// File: rtl/ffc_pkg.sv
// types for the flyback fault and soft-start logic
package ffc_pkg;
  typedef enum logic [2:0] {
    ffc_st_off,
    ffc_st_soft,
    ffc_st_run,
    ffc_st_retry,
    ffc_st_latch,
    ffc_st_sleep
  } ffc_state_t;
endpackage

// File: rtl/ffc_tmr_if.sv
// qualification timer hookup between the controller and its timers
`timescale 1ns/1ps
interface ffc_tmr_if;
  logic        run;
  logic [31:0] limit;
  logic        done;
  modport tmr  (input run, input limit, output done);
  modport user (output run, output limit, input done);
endinterface

// File: rtl/ffc_qual.sv
// qualification timer: done once run has held for limit cycles
`timescale 1ns/1ps
module ffc_qual (
  input  wire logic clk,
  input  wire logic nrst,
  ffc_tmr_if.tmr    t
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        done_reg;

  // count while run holds, restart as soon as it drops
  assign cnt_next = !t.run ? 32'h0 : (cnt_reg == t.limit) ? cnt_reg : cnt_reg + 32'h1;
  assign t.done   = done_reg;

  // counter and expiry flag
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_reg  <= 32'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      done_reg <= t.run && (cnt_next == t.limit);
    end
  end
endmodule

// File: test/ffc_top_properties.sv
// port assertions for the flyback control block
`timescale 1ns/1ps
`include "ffc_regs.svh"
module ffc_top_properties (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        fb_opc_above,
  input wire logic        line_ok,
  input wire logic        line_cmp,
  input wire logic        gate_drive,
  input wire logic [3:0]  softstart_step,
  input wire logic [15:0] slope_ramp,
  input wire logic        opc_enable,
  input wire logic        line_peak_valid,
  input wire logic        line_peak_clear,
  input wire logic        internal_supply_on,
  input wire logic        startup_source_on,
  input wire logic        protect_latched
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  int unsigned on_cnt;
  logic        run_ok;
  // no stop request is visible at the ports
  assign run_ok = line_ok && internal_supply_on && startup_source_on && !protect_latched;
  // cycles the gate has been high in the present pulse
  always_ff @(posedge clk)
  begin
    if (!nrst || !gate_drive)
      on_cnt <= 0;
    else
      on_cnt <= on_cnt + 1;
  end
  AST_BLANK: assert property ($fell(gate_drive) && run_ok |-> on_cnt > `FFC_LEB_CYC)
    else $error("gate fell inside blanking");
  AST_MAXON: assert property (gate_drive |-> on_cnt <= `FFC_MAXON_SLOW_CYC)
    else $error("gate pulse too long");
  AST_LATCH_OFF: assert property (protect_latched |-> !gate_drive)
    else $error("gate on while latched");
  AST_SLEEP_OFF: assert property (!internal_supply_on |-> !gate_drive)
    else $error("gate on in off mode");
  AST_HOT_OFF: assert property (!startup_source_on |-> !gate_drive)
    else $error("gate on while hot");
  AST_BROWNOUT: assert property ((!line_ok)[*6] |-> !protect_latched)
    else $error("latch held in brown-out");
  AST_STEP: assert property ($changed(softstart_step) |-> softstart_step == 4'h0 ||
    softstart_step == $past(softstart_step) + 4'h1)
    else $error("soft-start step skipped");
  AST_RAMP: assert property ($changed(slope_ramp) |-> slope_ramp == 16'h0 ||
    slope_ramp == $past(slope_ramp) + 16'h000d)
    else $error("sawtooth step wrong");
  AST_OPC: assert property ((!fb_opc_above)[*5] |-> !opc_enable)
    else $error("compensation on at light load");
  AST_CLR_PULSE: assert property (line_peak_clear |=> !line_peak_clear)
    else $error("clear pulse too long");
  AST_CMP_EDGE: assert property ($changed(line_cmp) |-> ##[1:4] !line_peak_valid)
    else $error("peak valid kept after edge");
  // main scenarios reached
  cover property ($rose(gate_drive));
  cover property ($rose(protect_latched));
  cover property ($rose(line_peak_valid));
  cover property ($fell(internal_supply_on));
endmodule
bind ffc_top ffc_top_properties i_ffc_top_properties (.clk, .nrst, .fb_opc_above, .line_ok,
  .line_cmp, .gate_drive, .softstart_step, .slope_ramp, .opc_enable, .line_peak_valid,
  .line_peak_clear, .internal_supply_on, .startup_source_on, .protect_latched);

// File: test/ffc_analog_model.sv
// current-sense comparators seen through the switch and its sense resistor
`timescale 1ns/1ps
module ffc_analog_model (
  input  wire logic       clk,
  input  wire logic       gate_drive,
  input  wire logic [3:0] softstart_step,
  input  wire logic [31:0] fb_at,
  input  wire logic [31:0] lim_at,
  input  wire logic       short_en,
  output logic            cs_fb_trip,
  output logic            cs_limit_trip,
  output logic            cs_soft_trip,
  output logic            cs_stop_trip,
  output logic            cs_tran_trip
);
  int ramp;
  // sensed current climbs while the switch conducts and drops when it opens
  always @(posedge clk)
  begin
    ramp <= gate_drive ? ramp + 1 : 0;
  end
  // comparator outputs, all zero while the switch is open
  assign cs_fb_trip    = gate_drive && ramp >= fb_at;
  assign cs_limit_trip = gate_drive && ramp >= lim_at;
  assign cs_soft_trip  = gate_drive && ramp * 15 >= lim_at * softstart_step;
  assign cs_stop_trip  = gate_drive && short_en;
  assign cs_tran_trip  = gate_drive && ramp >= 260;
endmodule

// File: test/tb_ffc_top.sv
// self-checking bench for the flyback control block
`timescale 1ns/1ps
`include "ffc_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_ffc_top;
  logic clk = 1'b0, nrst = 1'b0, fb_opc_above = 1'b0, fb_off_below = 1'b0;
  logic fb_on_above = 1'b1, sup_st = 1'b1, sup_low = 1'b0, line_ok = 1'b1;
  logic line_cmp = 1'b0, smp = 1'b0, clr = 1'b0, hot = 1'b0, ext = 1'b0;
  logic retry = 1'b0, short_en = 1'b0, sup_high = 1'b0, off_long = 1'b0;
  logic [2:0] line_adc = 3'h0, adc;
  logic cfb, clim, csoft, cstop, ctran, gate_drive, opc_enable, peak_valid, peak_clear;
  logic sup_on, src_on, protect_latched;
  logic [3:0] softstart_step;
  logic [15:0] slope_ramp;
  logic [2:0] line_peak;
  int fb_at = 40, lim_at = 300, w, k, num_errors = 0, tests_run = 0;
  logic [31:0] seed = 32'h8c3e;
  // analog side of the controller
  ffc_analog_model i_ffc_analog_model (.clk, .gate_drive, .softstart_step, .fb_at, .lim_at,
    .short_en, .cs_fb_trip(cfb), .cs_limit_trip(clim), .cs_soft_trip(csoft),
    .cs_stop_trip(cstop), .cs_tran_trip(ctran));
  ffc_top #(.SS_CYC(150), .FAULT_CYC(1500), .RETRY_CYC(1000), .TRAN_CYC(4000),
    .OFF_SHORT_CYC(600), .OFF_LONG_CYC(800)) i_ffc_top (.clk, .nrst, .cs_fb_trip(cfb),
    .cs_limit_trip(clim), .cs_soft_trip(csoft), .cs_stop_trip(cstop), .cs_tran_trip(ctran),
    .fb_opc_above, .fb_off_below, .fb_on_above, .supply_start_above(sup_st),
    .supply_low_below(sup_low), .supply_high_above(sup_high), .line_ok, .line_cmp, .line_adc,
    .line_sample_evt(smp), .line_clear_evt(clr), .thermal_shutdown(hot),
    .ext_latch_req(ext), .opt_freq_fast(1'b0), .opt_auto_retry(retry),
    .opt_off_long(off_long), .gate_drive, .softstart_step, .slope_ramp, .opc_enable,
    .line_peak, .line_peak_valid(peak_valid), .line_peak_clear(peak_clear),
    .internal_supply_on(sup_on), .startup_source_on(src_on), .protect_latched);
  // 40 MHz clock
  always #12.5 clk = ~clk;
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // pulse width expected once blanking and two sync flops are passed
  function automatic logic width_ok(input int at, input int wd);
    int e;
    e = (at > 10) ? at : 10;
    return wd > e && wd <= e + 6;
  endfunction
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic hold(input int n);
    repeat (n) tick();
  endtask
  // waits up to lim cycles for a gate pulse and returns its width
  task automatic pulse(input int lim, output int wd);
    int n;
    n = 0;
    wd = 0;
    while (gate_drive !== 1'b1 && n < lim)
    begin
      tick();
      n++;
    end
    while (gate_drive === 1'b1 && wd < 1000)
    begin
      tick();
      wd++;
    end
  endtask
  // brown-out clears any latch, then a fresh start
  task automatic recover();
    line_ok = 1'b0;
    hold(10);
    `CHK(protect_latched, 1'b0)
    line_ok = 1'b1;
    fb_at = 40;
    lim_at = 300;
    hold(800);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #(80000 * 25);
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    hold(20);
    nrst = 1'b1;
    hold(40);
    `CHK(softstart_step < 4'hf, 1'b1)
    hold(200);
    `CHK(softstart_step, 4'hf)
    $display("soft-start done");
    k = 0;
    while (slope_ramp !== 16'h0000 && k < 700)
    begin
      tick();
      k++;
    end
    tick();
    `CHK(slope_ramp, {8'h00, `FFC_SLOPE_SLOW})
    for (int i = 0; i < 9; i++)
    begin
      pulse(1500, w);
      seed = xorshift(seed);
      fb_at = (i == 0) ? 2 : 12 + seed % 200;
      pulse(1500, w);
      `CHK(width_ok(fb_at, w), 1'b1)
    end
    $display("feedback pulses done");
    for (int i = 0; i < 6; i++)
    begin
      lim_at = (i == 2 || i == 5) ? 300 : 50;
      fb_at = (i == 2 || i == 5) ? 40 : 1000;
      pulse(1500, w);
      `CHK(width_ok(fb_at < lim_at ? fb_at : lim_at, w), 1'b1)
    end
    `CHK(protect_latched, 1'b0)
    fb_at = 1000;
    lim_at = 1000;
    pulse(1500, w);
    `CHK(w >= `FFC_MAXON_SLOW_CYC - 1 && w <= `FFC_MAXON_SLOW_CYC + 1, 1'b1)
    hold(3000);
    `CHK(protect_latched, 1'b1)
    recover();
    $display("overload done");
    ext = 1'b1;
    hold(2000);
    ext = 1'b0;
    hold(20);
    `CHK(protect_latched, 1'b0)
    ext = 1'b1;
    hold(2300);
    ext = 1'b0;
    hold(50);
    `CHK(protect_latched, 1'b1)
    recover();
    sup_low = 1'b1;
    hold(450);
    sup_low = 1'b0;
    `CHK(protect_latched, 1'b1)
    recover();
    sup_high = 1'b1;
    hold(450);
    sup_high = 1'b0;
    `CHK(protect_latched, 1'b1)
    sup_st = 1'b0;
    line_ok = 1'b0;
    hold(10);
    `CHK(protect_latched, 1'b0)
    line_ok = 1'b1;
    pulse(800, w);
    `CHK(w, 0)
    sup_st = 1'b1;
    pulse(1500, w);
    `CHK(w > 0, 1'b1)
    $display("latch faults done");
    off_long = 1'b1;
    hot = 1'b1;
    hold(450);
    `CHK(src_on, 1'b0)
    hot = 1'b0;
    pulse(3000, w);
    `CHK(w > 0, 1'b1)
    `CHK(src_on, 1'b1)
    fb_off_below = 1'b1;
    fb_on_above = 1'b0;
    hold(700);
    `CHK(sup_on, 1'b1)
    hold(150);
    `CHK(sup_on, 1'b0)
    fb_off_below = 1'b0;
    hold(100);
    `CHK(sup_on, 1'b0)
    fb_on_above = 1'b1;
    hold(20);
    `CHK(sup_on, 1'b1)
    hold(800);
    fb_opc_above = 1'b1;
    hold(8);
    `CHK(opc_enable, 1'b1)
    fb_opc_above = 1'b0;
    hold(8);
    `CHK(opc_enable, 1'b0)
    $display("thermal off opc done");
    line_cmp = 1'b1;
    hold(5);
    line_cmp = 1'b0;
    hold(8);
    for (int i = 0; i < 2; i++)
    begin
      seed = xorshift(seed);
      adc = seed[2:0];
      line_adc = adc;
      hold(4);
      smp = 1'b1;
      hold(4);
      smp = 1'b0;
      hold(6);
      `CHK(line_peak, adc)
      `CHK(peak_valid, (i == 1) ? 1'b1 : 1'b0)
    end
    line_cmp = 1'b1;
    hold(6);
    `CHK(peak_valid, 1'b0)
    clr = 1'b1;
    k = 0;
    for (int i = 0; i < 8; i++)
    begin
      tick();
      k += (peak_clear === 1'b1);
    end
    clr = 1'b0;
    `CHK(k, 1)
    $display("line peak done");
    fb_at = 270;
    hold(5500);
    `CHK(protect_latched, 1'b1)
    line_ok = 1'b0;
    retry = 1'b1;
    fb_at = 40;
    hold(10);
    line_ok = 1'b1;
    hold(800);
    pulse(1500, w);
    short_en = 1'b1;
    k = 0;
    do
    begin
      pulse(700, w);
      k += (w > 0);
    end
    while (w > 0 && k < 9);
    short_en = 1'b0;
    `CHK(k, 4)
    pulse(3000, w);
    `CHK(w > 0, 1'b1)
    hold(300);
    pulse(700, w);
    `CHK(w > 0, 1'b1)
    $display("short and retry done");
    give_verdict();
  end
endmodule
